/* pkg/acr_pkg.sv */
// shared constants and types for the converter control block
package acr_pkg;
  localparam int NCH = 2;                     // control / result pairs

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // chan_ctrl_first, then next
  localparam logic [7:0] CTRL_STEP  = 8'h04;  // stride of control regs
  localparam logic [7:0] OFF_CFG1   = 8'h08;  // converter_config_one
  localparam logic [7:0] OFF_CFG2   = 8'h0C;  // converter_config_two
  localparam logic [7:0] OFF_SC2    = 8'h10;  // status_control_two
  localparam logic [7:0] OFF_CV1H   = 8'h14;  // compare_one_high
  localparam logic [7:0] OFF_CV1L   = 8'h18;  // compare_one_low
  localparam logic [7:0] OFF_CV2H   = 8'h1C;  // compare_two_high
  localparam logic [7:0] OFF_CV2L   = 8'h20;  // compare_two_low
  localparam logic [7:0] OFF_RH     = 8'h24;  // result_high_byte, pair 0
  localparam logic [7:0] OFF_RL     = 8'h28;  // result_low_byte, pair 0
  localparam logic [7:0] RES_STEP   = 8'h08;  // stride of result pairs

  // field positions
  localparam int CTRL_COCO_BIT = 7;           // conv_complete_flag
  localparam int CTRL_DIFF_BIT = 5;           // differential_en
  localparam int CFG1_LSMP_BIT = 4;           // long_sample_en
  localparam int CFG2_CKEN_BIT = 3;           // async_clk_out_en
  localparam int CFG2_HSC_BIT  = 2;           // high_speed_cfg
  localparam int SC2_ACT_BIT   = 7;           // conv_active
  localparam int SC2_TRG_BIT   = 6;           // trigger_sel
  localparam int SC2_CFE_BIT   = 5;           // compare_en
  localparam int SC2_CGT_BIT   = 4;           // compare_greater_en
  localparam int SC2_CREN_BIT  = 3;           // compare_range_en

  // values after reset and codes
  localparam logic [6:0] RST_CTRL   = 7'h1F;  // channel off
  localparam logic [7:0] RST_BYTE   = 8'h00;  // all other registers
  localparam logic [4:0] CHAN_OFF   = 5'h1F;  // converter disabled code
  localparam logic [1:0] CLK_ASYNC  = 2'h3;   // input_clk_sel async code
  localparam logic [1:0] REF_RSVD   = 2'h3;   // reserved reference code
  localparam logic [1:0] REF_DFLT   = 2'h0;   // default reference pair

  // cycle counts in conversion clock cycles
  localparam logic [5:0] LS_TOTAL_0 = 6'h18;  // 24 cycles
  localparam logic [5:0] LS_TOTAL_1 = 6'h10;  // 16 cycles
  localparam logic [5:0] LS_TOTAL_2 = 6'h0A;  // 10 cycles
  localparam logic [5:0] LS_TOTAL_3 = 6'h06;  // 6 cycles
  localparam logic [5:0] SHORT_SMP  = 6'h04;  // short sample time
  localparam logic [5:0] BASE_CONV  = 6'h14;  // normal convert phase
  localparam logic [5:0] HSC_EXTRA  = 6'h04;  // high speed extension
  localparam logic [1:0] ASYNC_HALF = 2'h1;   // async half period less one, mclk

  // sequencer configuration captured at start
  typedef struct packed {
    logic       long_en;                      // long_sample_en
    logic [1:0] long_sel;                     // long_sample_sel
    logic       high_speed;                   // high_speed_cfg
  } acr_seq_cfg_type;

  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_SAMPLE  = 3'b010,
    SEQ_CONVERT = 3'b100
  } acr_seq_state_type;
endpackage

/* core/acr_conv_seq.sv */
// conversion sequencer: sample phase then convert phase
`timescale 1ns/1ps
module acr_conv_seq (
  input  wire logic                     mclk,     // system clock
  input  wire logic                     reset_n,  // async reset, low
  input  wire logic                     tick,     // conv_clk enable
  input  wire logic                     start,    // begin conversion
  input  wire logic                     abort,    // stop conversion
  input  wire acr_pkg::acr_seq_cfg_type cfg,      // timing options
  output logic                          busy,     // conversion running
  output logic                          sampling, // sample phase
  output logic                          done      // completion pulse
);
  acr_pkg::acr_seq_state_type state_q;            // phase
  logic [5:0]                 cnt_q;              // cycles left
  logic                       hs_q;               // captured hs option
  logic [5:0]                 smp_len;            // sample length
  logic [5:0]                 cnv_len;            // convert length
  logic                       last;               // final cycle of phase

  // sample time from long sample options
  always_comb begin
    smp_len = acr_pkg::SHORT_SMP;
    if (cfg.long_en) begin
      unique case (cfg.long_sel)
        2'h0: smp_len = acr_pkg::LS_TOTAL_0;
        2'h1: smp_len = acr_pkg::LS_TOTAL_1;
        2'h2: smp_len = acr_pkg::LS_TOTAL_2;
        2'h3: smp_len = acr_pkg::LS_TOTAL_3;
      endcase
    end
  end

  assign cnv_len = hs_q ? acr_pkg::BASE_CONV + acr_pkg::HSC_EXTRA
                        : acr_pkg::BASE_CONV;
  assign last    = tick & (cnt_q == 6'h01);
  assign busy    = (state_q != acr_pkg::SEQ_IDLE);
  assign sampling = (state_q == acr_pkg::SEQ_SAMPLE);

  // phase walk; start wins over abort so a rewrite restarts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= acr_pkg::SEQ_IDLE;
      cnt_q   <= 6'h00;
      hs_q    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        state_q <= acr_pkg::SEQ_SAMPLE;
        cnt_q   <= smp_len;
        hs_q    <= cfg.high_speed;
      end else if (abort) begin
        state_q <= acr_pkg::SEQ_IDLE;
      end else begin
        unique case (state_q)
          acr_pkg::SEQ_IDLE: begin
            cnt_q <= 6'h00;
          end
          acr_pkg::SEQ_SAMPLE: begin
            if (last) begin
              state_q <= acr_pkg::SEQ_CONVERT;
              cnt_q   <= cnv_len;
            end else if (tick) begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
          acr_pkg::SEQ_CONVERT: begin
            if (last) begin
              state_q <= acr_pkg::SEQ_IDLE;
              done    <= 1'b1;
            end else if (tick) begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
        endcase
      end
    end
  end
endmodule

/* core/acr_top.sv */
// converter control registers, results, compare and ahb-lite slave
//
// Overview of operation
// - clock out enable runs async clock always
// - high speed adds four conversion cycles
// - long select gives 24, 16, 10, 6
// - one result pair per control register
// - high byte read locks pair until low
// - result completing while locked is discarded
// - 8-bit single-ended has no lock
// - low byte low bits, high byte rest
// - zero fill unsigned, sign fill differential
// - per-mode result widths and justification
// - compare values formatted like results
// - second compare value used only in range
// - 8-bit single-ended ignores compare one high
// - active flag set at start, cleared end
// - software trigger on first control write
// - hardware trigger after select pulse, assertion
// - compare enable gates greater and range
// - greater bit picks inclusive or strict tests
// - range bit uses both compare values
// - reference select, reserved means default
// - compare true required to set complete
// - input clock select picks conversion clock
// - long select applies only with long enable
// - mode and differential choose resolution
`timescale 1ns/1ps
module acr_top (
  input  wire logic                    mclk,        // 125 MHz clock
  input  wire logic                    reset_n,     // async reset, low
  input  wire logic                    hsel,        // slave select
  input  wire logic [31:0]             haddr,       // byte address
  input  wire logic [1:0]              htrans,      // transfer type
  input  wire logic                    hwrite,      // write access
  input  wire logic [2:0]              hsize,       // word only
  input  wire logic [31:0]             hwdata,      // write data
  input  wire logic                    hready,      // bus ready
  output logic      [31:0]             hrdata,      // read data
  output logic                         hreadyout,   // slave ready
  output logic                         hresp,       // always okay
  input  wire logic                    alt_clk_tick, // alternate clk
  input  wire logic                    hw_trigger_in, // hw trigger
  input  wire logic [acr_pkg::NCH-1:0] hw_trigger_select_in, // pick
  input  wire logic [15:0]             conv_data_in, // raw code
  output logic                         async_clk_out, // async clock
  output logic                         conv_active_o, // busy
  output logic                         conv_sample_o, // sampling
  output logic      [4:0]              conv_chan_o, // channel
  output logic                         conv_diff_o, // differential
  output logic      [1:0]              ref_sel_o    // reference used
);
  localparam int N = acr_pkg::NCH;                 // pair count

  // register state
  logic [6:0]  ctrl_q [N];                         // control fields
  logic [15:0] res_q  [N];                         // result pairs
  logic [N-1:0] coco_q;                            // complete flags
  logic [N-1:0] lock_q;                            // read interlocks
  logic [7:0]  cfg1_q;                             // config one
  logic [3:0]  cfg2_q;                             // config two
  logic [6:0]  sc2_q;                              // status two rw part
  logic [7:0]  cv1h_q, cv1l_q, cv2h_q, cv2l_q;     // compare values

  // bus pipeline
  logic        wr_pend_q;                          // write data phase
  logic [7:0]  wr_addr_q;                          // latched address
  logic [7:0]  rd_mux;                             // read selection

  // conversion bookkeeping
  logic        act_idx_q;                          // active pair
  logic        act_diff_q;                         // active diff mode
  logic        hw_prev_q;                          // trigger history
  logic        armed_q;                            // select seen
  logic        hw_idx_q;                           // selected pair
  logic        div2_q;                             // bus clock / 2
  logic [1:0]  asy_cnt_q;                          // async divider
  logic        asy_clk_q;                          // async clock level

  // sequencer links
  logic        seq_busy, seq_smp, seq_done;        // sequencer status
  acr_pkg::acr_seq_cfg_type seq_cfg;               // timing options

  // bus decode
  wire        addr_ok = hsel & htrans[1] & hready;
  wire        rd_go   = addr_ok & ~hwrite;
  wire [7:0]  rd_addr = haddr[7:0];
  wire [7:0]  wdata   = hwdata[7:0];
  wire        w_cfg1  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CFG1);
  wire        w_cfg2  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CFG2);
  wire        w_sc2   = wr_pend_q & (wr_addr_q == acr_pkg::OFF_SC2);
  wire        w_cv1h  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CV1H);
  wire        w_cv1l  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CV1L);
  wire        w_cv2h  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CV2H);
  wire        w_cv2l  = wr_pend_q & (wr_addr_q == acr_pkg::OFF_CV2L);
  logic [N-1:0] w_ctrl, r_rh, r_rl;               // per-pair strobes

  // option fields
  wire [1:0] mode   = cfg1_q[3:2];                 // resolution
  wire [1:0] icsel  = cfg1_q[1:0];                 // input clock select
  wire       trg    = sc2_q[acr_pkg::SC2_TRG_BIT];
  wire       cfe    = sc2_q[acr_pkg::SC2_CFE_BIT];
  wire       cgt    = sc2_q[acr_pkg::SC2_CGT_BIT];
  wire       cren   = sc2_q[acr_pkg::SC2_CREN_BIT];

  // result layout per mode and differential
  function automatic logic [15:0] fmt_f(input logic [15:0] d,
                                        input logic [1:0]  m,
                                        input logic        df);
    logic [15:0] r;
    r = d;
    unique case ({m, df})
      3'b000: r = {8'h00, d[7:0]};
      3'b001: r = {{7{d[8]}}, d[8:0]};
      3'b010: r = {4'h0, d[11:0]};
      3'b011: r = {{3{d[12]}}, d[12:0]};
      3'b100: r = {6'h00, d[9:0]};
      3'b101: r = {{5{d[10]}}, d[10:0]};
      3'b110: r = d;
      3'b111: r = d;
    endcase
    return r;
  endfunction

  // signed values compare as offset binary
  function automatic logic [15:0] key_f(input logic [15:0] v,
                                        input logic        df);
    return df ? {~v[15], v[14:0]} : v;
  endfunction

  wire [15:0] res_fmt = fmt_f(conv_data_in, mode, act_diff_q);
  wire [15:0] cv1_fmt = fmt_f({cv1h_q, cv1l_q}, mode, act_diff_q);
  wire [15:0] cv2_fmt = fmt_f({cv2h_q, cv2l_q}, mode, act_diff_q);
  wire [15:0] k_r  = key_f(res_fmt, act_diff_q);
  wire [15:0] k_1  = key_f(cv1_fmt, act_diff_q);
  wire [15:0] k_2  = key_f(cv2_fmt, act_diff_q);
  wire        ge1  = (k_r >= k_1);
  wire        le2  = (k_r <= k_2);
  wire        ord  = (k_1 <= k_2);                 // cv1 at or below cv2

  wire cmp_one = cgt ? ge1 : ~ge1;
  wire cmp_rng = cgt ? (ord ? (ge1 & le2) : (ge1 | le2))
                     : (ord ? (~ge1 | ~le2) : (~ge1 & ~le2));
  wire cmp_hit = cren ? cmp_rng : cmp_one;
  wire cmp_ok  = ~cfe | cmp_hit;

  // trigger sources
  wire [4:0] w_chan  = wdata[4:0];
  wire sw_start = w_ctrl[0] & ~trg & (w_chan != acr_pkg::CHAN_OFF);
  wire hw_rise  = hw_trigger_in & ~hw_prev_q;
  wire hw_chan_on = ctrl_q[hw_idx_q][4:0] != acr_pkg::CHAN_OFF;
  wire hw_start = trg & armed_q & hw_rise & hw_chan_on;
  wire start    = sw_start | hw_start;
  wire start_ix = sw_start ? 1'b0 : hw_idx_q;
  wire start_df = sw_start ? wdata[acr_pkg::CTRL_DIFF_BIT]
                           : ctrl_q[hw_idx_q][acr_pkg::CTRL_DIFF_BIT];
  wire [4:0] start_ch = sw_start ? w_chan : ctrl_q[hw_idx_q][4:0];
  wire abort = seq_busy & w_ctrl[act_idx_q];      // rewrite active reg
  wire sel_ix = hw_trigger_select_in[N-1];        // last select pulsed

  wire asy_rise = (asy_cnt_q == acr_pkg::ASYNC_HALF) & ~asy_clk_q;
  wire tick = (icsel == 2'h0) ? 1'b1 :
              (icsel == 2'h1) ? div2_q :
              (icsel == 2'h2) ? alt_clk_tick : asy_rise;
  wire asy_run = cfg2_q[acr_pkg::CFG2_CKEN_BIT] |
                 ((icsel == acr_pkg::CLK_ASYNC) & seq_busy);

  // options captured by the sequencer at start
  assign seq_cfg.long_en    = cfg1_q[acr_pkg::CFG1_LSMP_BIT];
  assign seq_cfg.long_sel   = cfg2_q[1:0];
  assign seq_cfg.high_speed = cfg2_q[acr_pkg::CFG2_HSC_BIT];

  acr_conv_seq u_seq (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .tick     (tick),
    .start    (start),
    .abort    (abort),
    .cfg      (seq_cfg),
    .busy     (seq_busy),
    .sampling (seq_smp),
    .done     (seq_done)
  );

  // per-pair control, result, flag and interlock
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pair
      localparam logic [7:0] A_CTRL =
        acr_pkg::OFF_CTRL + 8'(8'(i) * acr_pkg::CTRL_STEP);
      localparam logic [7:0] A_RH =
        acr_pkg::OFF_RH + 8'(8'(i) * acr_pkg::RES_STEP);
      localparam logic [7:0] A_RL =
        acr_pkg::OFF_RL + 8'(8'(i) * acr_pkg::RES_STEP);
      wire se8 = (mode == 2'h0) & ~ctrl_q[i][acr_pkg::CTRL_DIFF_BIT];
      wire fin = seq_done & (act_idx_q == 1'(i));
      assign w_ctrl[i] = wr_pend_q & (wr_addr_q == A_CTRL);
      assign r_rh[i]   = rd_go & (rd_addr == A_RH);
      assign r_rl[i]   = rd_go & (rd_addr == A_RL);
      wire store = fin & cmp_ok & (~lock_q[i] | se8);
      wire set_c = fin & cmp_ok;
      wire clr_c = w_ctrl[i] | r_rl[i];

      // flags: a completion beats a clear in the same cycle
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_q[i] <= acr_pkg::RST_CTRL;
          res_q[i]  <= 16'h0000;
          coco_q[i] <= 1'b0;
          lock_q[i] <= 1'b0;
        end else begin
          if (w_ctrl[i]) begin
            ctrl_q[i] <= wdata[6:0];
          end
          if (store) begin
            res_q[i] <= res_fmt;
          end
          coco_q[i] <= set_c | (coco_q[i] & ~clr_c);
          lock_q[i] <= (r_rh[i] & ~se8) | (lock_q[i] & ~r_rl[i]);
        end
      end
    end
  endgenerate

  // read selection, unmapped reads as zero
  always_comb begin
    rd_mux = 8'h00;
    for (int k = 0; k < N; k++) begin
      if (rd_addr == acr_pkg::OFF_CTRL +
          8'(8'(k) * acr_pkg::CTRL_STEP)) begin
        rd_mux = {coco_q[k], ctrl_q[k]};
      end
      if (rd_addr == acr_pkg::OFF_RH +
          8'(8'(k) * acr_pkg::RES_STEP)) begin
        rd_mux = res_q[k][15:8];
      end
      if (rd_addr == acr_pkg::OFF_RL +
          8'(8'(k) * acr_pkg::RES_STEP)) begin
        rd_mux = res_q[k][7:0];
      end
    end
    unique case (rd_addr)
      acr_pkg::OFF_CFG1: rd_mux = cfg1_q;
      acr_pkg::OFF_CFG2: rd_mux = {4'h0, cfg2_q};
      acr_pkg::OFF_SC2:  rd_mux = {seq_busy, sc2_q};
      acr_pkg::OFF_CV1H: rd_mux = cv1h_q;
      acr_pkg::OFF_CV1L: rd_mux = cv1l_q;
      acr_pkg::OFF_CV2H: rd_mux = cv2h_q;
      acr_pkg::OFF_CV2L: rd_mux = cv2l_q;
      default: ;
    endcase
  end

  // ahb-lite slave: zero wait, read data registered in address phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok) begin
        wr_addr_q <= rd_addr;
      end
      if (rd_go) begin
        hrdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // software configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg1_q <= acr_pkg::RST_BYTE;
      cfg2_q <= acr_pkg::RST_BYTE[3:0];
      sc2_q  <= acr_pkg::RST_BYTE[6:0];
      cv1h_q <= acr_pkg::RST_BYTE;
      cv1l_q <= acr_pkg::RST_BYTE;
      cv2h_q <= acr_pkg::RST_BYTE;
      cv2l_q <= acr_pkg::RST_BYTE;
    end else begin
      if (w_cfg1) cfg1_q <= wdata;
      if (w_cfg2) cfg2_q <= wdata[3:0];
      // bit 2 of this register is reserved and stays zero
      if (w_sc2)  sc2_q  <= {wdata[6:3], 1'b0, wdata[1:0]};
      if (w_cv1h) cv1h_q <= wdata;
      if (w_cv1l) cv1l_q <= wdata;
      if (w_cv2h) cv2h_q <= wdata;
      if (w_cv2l) cv2l_q <= wdata;
    end
  end

  // trigger arming and active pair tracking
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hw_prev_q  <= 1'b0;
      armed_q    <= 1'b0;
      hw_idx_q   <= 1'b0;
      act_idx_q  <= 1'b0;
      act_diff_q <= 1'b0;
    end else begin
      hw_prev_q <= hw_trigger_in;
      // a fresh select pulse is needed for every hardware start
      if (|hw_trigger_select_in) begin
        armed_q  <= 1'b1;
        hw_idx_q <= sel_ix;
      end else if (hw_start) begin
        armed_q <= 1'b0;
      end
      if (start) begin
        act_idx_q  <= start_ix;
        act_diff_q <= start_df;
      end
    end
  end

  // clock sources: bus/2 and async divider
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div2_q    <= 1'b0;
      asy_cnt_q <= 2'h0;
      asy_clk_q <= 1'b0;
    end else begin
      div2_q <= ~div2_q;
      if (!asy_run) begin
        asy_cnt_q <= 2'h0;
        asy_clk_q <= 1'b0;
      end else if (asy_cnt_q == acr_pkg::ASYNC_HALF) begin
        asy_cnt_q <= 2'h0;
        asy_clk_q <= ~asy_clk_q;
      end else begin
        asy_cnt_q <= asy_cnt_q + 2'h1;
      end
    end
  end

  // registered status outputs, one cycle behind internal state except channel and diff, loaded at start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      async_clk_out <= 1'b0;
      conv_active_o <= 1'b0;
      conv_sample_o <= 1'b0;
      conv_chan_o   <= acr_pkg::CHAN_OFF;
      conv_diff_o   <= 1'b0;
      ref_sel_o     <= acr_pkg::REF_DFLT;
    end else begin
      async_clk_out <= asy_clk_q;
      conv_active_o <= seq_busy;
      conv_sample_o <= seq_smp;
      if (start) begin
        conv_chan_o <= start_ch;
        conv_diff_o <= start_df;
      end
      ref_sel_o <= (sc2_q[1:0] == acr_pkg::REF_RSVD) ?
                   acr_pkg::REF_DFLT : sc2_q[1:0];
    end
  end

  // word size is the only one used; hsize is accepted as is
  wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8]};
endmodule

/* sim/acr_props.sv */
// bound checker on the converter control block ports
`timescale 1ns/1ps
module acr_props (
  input wire logic        mclk,          // clock
  input wire logic        reset_n,       // reset, low
  input wire logic        hsel,          // select
  input wire logic [1:0]  htrans,        // transfer
  input wire logic        hwrite,        // write
  input wire logic        hready,        // ready in
  input wire logic [31:0] hrdata,        // read data
  input wire logic        hreadyout,     // ready out
  input wire logic        hresp,         // response
  input wire logic        conv_active_o, // busy
  input wire logic        conv_sample_o, // sampling
  input wire logic [4:0]  conv_chan_o,   // channel
  input wire logic        conv_diff_o,   // differential
  input wire logic [1:0]  ref_sel_o      // reference
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // only a read address phase may load new read data
  wire rd_ph = hsel & htrans[1] & ~hwrite & hready; // read taken
  sequence s_smp4; conv_sample_o [*4]; endsequence
  sequence s_act2; ##[0:2] conv_active_o; endsequence
  property p_rdy; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_hi; hrdata[31:8] == 24'h000000; endproperty
  property p_rdch; $changed(hrdata) |-> $past(rd_ph); endproperty
  property p_ref; ref_sel_o != 2'h3; endproperty
  property p_smp; $rose(conv_sample_o) |-> s_smp4; endproperty
  property p_act; $rose(conv_active_o) |-> conv_sample_o; endproperty
  property p_in; conv_sample_o |-> conv_active_o; endproperty
  property p_st; $changed({conv_chan_o, conv_diff_o}) |-> s_act2; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  a_okay: assert property (p_okay) else $error("bad response");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_rdch: assert property (p_rdch) else $error("read data moved");
  a_ref: assert property (p_ref) else $error("reserved reference");
  a_smp: assert property (p_smp) else $error("sample too short");
  a_act: assert property (p_act) else $error("start not sampling");
  a_in: assert property (p_in) else $error("sampling while idle");
  a_st: assert property (p_st) else $error("start without busy");
endmodule
bind acr_top acr_props acr_props_inst (.mclk, .reset_n, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .conv_active_o,
  .conv_sample_o, .conv_chan_o, .conv_diff_o, .ref_sel_o);

/* sim/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, hw_trigger_in = 0;
  logic [1:0]  htrans = 0, hw_trigger_select_in = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, h;
  logic [15:0] conv_data_in = 0;                // raw code
  logic hreadyout, hresp, async_clk_out, conv_active_o, conv_sample_o;
  logic [4:0]  conv_chan_o;
  logic        conv_diff_o, alt = 0;
  logic [1:0]  ref_sel_o;
  int n_mismatch = 0, num_checks = 0, cyc = 0, s, a, a0, k, n;
  // {cfg1, ctrl, raw, expected result} per mode
  localparam logic [47:0] MT [8] = '{48'h0000FFFF00FF, 48'h0400FFFF0FFF,
    48'h0800FFFF03FF, 48'h0C00FFFFFFFF, 48'h00200100FF00,
    48'h04201000F000, 48'h08200400FC00, 48'h0C2080008000};
  localparam int LT [4] = '{24, 16, 10, 6};     // long sample totals
  acr_top acr_top_inst (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .alt_clk_tick(alt), .hw_trigger_in, .hw_trigger_select_in,
    .conv_data_in, .async_clk_out, .conv_active_o, .conv_sample_o,
    .conv_chan_o, .conv_diff_o, .ref_sel_o);
  always #4 mclk = ~mclk;
  // hang guard, far above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // single transfer; address held until ready, then data phase
  task automatic ahb(input logic w, input logic [7:0] ad,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, ad};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    ahb(1'b1, ad, {24'h000000, d}, r);
  endtask
  // start by control write, count phases at the falling edge
  task automatic conv(input logic [7:0] c1, input logic [7:0] ct,
      input logic [15:0] d);
    s = 0;
    a = 0;
    wr(acr_pkg::OFF_CFG1, c1);
    conv_data_in <= d;
    wr(acr_pkg::OFF_CTRL, ct);
    for (k = 0; k < 200 && !(a > 0 && conv_active_o === 1'b0); k++) begin
      @(negedge mclk);
      s += conv_sample_o;
      a += conv_active_o;
    end
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk({27'h0, conv_chan_o}, 32'h1F);
    ahb(0, acr_pkg::OFF_CTRL, 0, r); chk(r, 32'h1F);
    ahb(0, acr_pkg::OFF_CFG2, 0, r); chk(r, 32'h0);
    ahb(0, 8'h3C, 0, r); chk(r, 32'h0);
    for (int i = 0; i < 8; i++) begin
      conv(MT[i][47:40], MT[i][39:32], MT[i][31:16]);
      ahb(0, acr_pkg::OFF_RH, 0, h);
      ahb(0, acr_pkg::OFF_RL, 0, r);
      chk({h[23:0], r[7:0]}, {16'h0, MT[i][15:0]});
      chk({conv_diff_o, conv_chan_o}, MT[i][37:32]);
    end
    conv(8'h04, 8'h00, 16'h0ABC);
    ahb(0, acr_pkg::OFF_RH, 0, h);
    conv(8'h04, 8'h00, 16'h0123);
    ahb(0, acr_pkg::OFF_RL, 0, r); chk(r, 32'hBC);
    ahb(0, acr_pkg::OFF_RH, 0, h); chk(h, 32'h0A);
    ahb(0, acr_pkg::OFF_RL, 0, r);
    conv(8'h00, 8'h00, 16'h0055);
    ahb(0, acr_pkg::OFF_RH, 0, h);
    conv(8'h00, 8'h00, 16'h0066);
    ahb(0, acr_pkg::OFF_RL, 0, r); chk(r, 32'h66);
    // high byte of compare one must not matter in 8-bit single-ended mode
    wr(acr_pkg::OFF_CV1H, 8'hFF);
    wr(acr_pkg::OFF_CV1L, 8'h80);
    wr(acr_pkg::OFF_CV2L, 8'h10);
    foreach (LT[i]) begin
      wr(acr_pkg::OFF_SC2, i == 0 ? 8'h20 : i == 1 ? 8'h30 :
         i == 2 ? 8'h18 : 8'h28);
      conv(8'h00, 8'h00, 16'h0090);
      ahb(0, acr_pkg::OFF_CTRL, 0, r);
      chk(r, i % 3 == 0 ? 32'h0 : 32'h80);
    end
    wr(acr_pkg::OFF_SC2, 8'h00);
    wr(acr_pkg::OFF_CFG2, 8'h03);
    conv(8'h00, 8'h00, 16'h0000); chk(s, 32'h4);
    a0 = a;
    wr(acr_pkg::OFF_CFG2, 8'h04);
    conv(8'h00, 8'h00, 16'h0000); chk(a - a0, 32'h4);
    foreach (LT[i]) begin
      wr(acr_pkg::OFF_CFG2, i[7:0]);
      conv(8'h10, 8'h00, 16'h0000); chk(s, LT[i]);
    end
    // alternate clock held low stalls the conversion until it ticks
    conv(8'h02, 8'h00, 16'h0000); chk(conv_active_o, 1);
    alt <= 1'b1;
    for (k = 0; k < 99 && conv_active_o !== 1'b0; k++) @(negedge mclk);
    chk(conv_active_o, 0);
    @(posedge mclk);
    // hardware start: select pulse, then trigger edge
    wr(acr_pkg::OFF_SC2, 8'h40);
    wr(acr_pkg::OFF_CTRL, 8'h00);
    hw_trigger_select_in <= 2'h1;
    @(posedge mclk);
    hw_trigger_select_in <= 2'h0;
    hw_trigger_in <= 1'b1;
    for (k = 0; k < 10 && conv_active_o !== 1'b1; k++) @(negedge mclk);
    chk({31'h0, conv_active_o}, 32'h1);
    @(posedge mclk);
    ahb(0, acr_pkg::OFF_SC2, 0, r); chk(r, 32'hC0);
    for (k = 0; k < 99 && conv_active_o !== 1'b0; k++) @(negedge mclk);
    repeat (2) @(posedge mclk);
    hw_trigger_in <= 1'b0;
    ahb(0, acr_pkg::OFF_SC2, 0, r); chk(r, 32'h40);
    ahb(0, acr_pkg::OFF_CTRL, 0, r); chk(r, 32'h80);
    for (int j = 0; j < 2; j++) begin
      wr(acr_pkg::OFF_CFG2, j == 0 ? 8'h08 : 8'h00);
      repeat (4) @(negedge mclk);
      n = 0;
      for (k = 0; k < 16; k++) begin
        h[0] = async_clk_out;
        @(negedge mclk);
        n += async_clk_out & ~h[0];
      end
      @(posedge mclk);
      chk(n, j == 0 ? 32'h4 : 32'h0);
    end
    for (int j = 3; j > 1; j--) begin
      wr(acr_pkg::OFF_SC2, j[7:0]);
      repeat (3) @(negedge mclk);
      chk({30'h0, ref_sel_o}, j == 3 ? 32'h0 : 32'h2);
      @(posedge mclk);
    end
    final_report;
  end
endmodule
